// ==== rtl/phyd_pkg.sv ====
/*
 * constants, field positions and types for the PHY port diagnostic
 * and status register bank.
 * assumes a 32-bit APB with 12-bit byte addresses, one word per register.
 */
package phyd_pkg;

	// ************************************************************
	// register indices and byte addresses (byte address = index * 4)
	// ************************************************************
	localparam logic [11:0] IDX_ABILITY   = 12'h056;
	localparam logic [11:0] IDX_SPECIAL   = 12'h066;
	localparam logic [11:0] IDX_LED_OVR   = 12'h06C;
	localparam logic [11:0] IDX_CABLE     = 12'h07C;
	localparam logic [11:0] IDX_MIRROR    = 12'h080;
	localparam logic [11:0] IDX_IRQ_STAT  = 12'h090;
	localparam logic [11:0] IDX_IRQ_MASK  = 12'h092;

	localparam logic [11:0] ADDR_ABILITY  = {IDX_ABILITY[9:0], 2'b00};
	localparam logic [11:0] ADDR_SPECIAL  = {IDX_SPECIAL[9:0], 2'b00};
	localparam logic [11:0] ADDR_LED_OVR  = {IDX_LED_OVR[9:0], 2'b00};
	localparam logic [11:0] ADDR_CABLE    = {IDX_CABLE[9:0], 2'b00};
	localparam logic [11:0] ADDR_MIRROR   = {IDX_MIRROR[9:0], 2'b00};
	localparam logic [11:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT[9:0], 2'b00};
	localparam logic [11:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK[9:0], 2'b00};

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int SPC_POL_BIT    = 5;
	localparam int SPC_MDIX_BIT   = 4;
	localparam int SPC_FORCE_BIT  = 3;
	localparam int SPC_LP10_BIT   = 2;
	localparam int SPC_LOOP_BIT   = 1;
	localparam int LED_OVR_LSB    = 12;
	localparam int CAB_SHORT_BIT  = 15;
	localparam int CAB_OUT_LSB    = 13;
	localparam int CAB_GO_BIT     = 12;
	localparam int CAB_FORCE_BIT  = 11;
	localparam int CAB_RSV_BIT    = 10;
	localparam int CAB_LOOP_BIT   = 9;
	localparam int IRQ_DONE_BIT   = 0;
	localparam int IRQ_POL_BIT    = 1;

	// ************************************************************
	// reset and fixed values
	// ************************************************************
	localparam logic [4:0] ABIL_LOW_RSV    = 5'h01;
	localparam logic       RST_LP10_DIS    = 1'b1;
	localparam logic       RST_CAB_RSV     = 1'b1;
	localparam logic [2:0] RST_LED_OVR     = 3'h0;
	localparam logic [1:0] OUT_FAILED      = 2'h3;
	localparam logic [1:0] RST_IRQ_MASK    = 2'h0;

	// ************************************************************
	// timing: cable test watchdog
	// ************************************************************
	localparam int CLK_MHZ          = 25;
	localparam int CABLE_TIMEOUT_US = 100;
	localparam int CABLE_TIMEOUT_CYC = CABLE_TIMEOUT_US * CLK_MHZ;

	// cable test engine states
	typedef enum logic [0:0] {
		CT_IDLE = 1'b0,
		CT_RUN  = 1'b1
	} phyd_ct_state_t;

endpackage

// ==== rtl/phyd_sync2.sv ====
/*
 * two flip-flop synchroniser for a group of level signals.
 * assumes each bit is a slow level; bits of a group may skew by one clock.
 */
`timescale 1ns/1ps
module phyd_sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             i_ref_clk,
	input  wire logic             i_nrst,
	// asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_reg;

	// first stage is read only by the second stage
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_reg <= '0;
			o_sync   <= '0;
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end

endmodule // phyd_sync2

// ==== rtl/phyd_led_drive.sv ====
/*
 * port indicator driver: normal mode pass-through or software override.
 * assumes the normal-mode levels come from logic on the same clock.
 */
`timescale 1ns/1ps
module phyd_led_drive (
	// clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_nrst,
	// override field and normal-mode levels
	input  wire logic [2:0] i_led_ovr,
	input  wire logic       i_mode_a,
	input  wire logic       i_mode_b,
	// indicator pins
	output logic            o_indicator_a,
	output logic            o_indicator_b
);

	// registered so the pins never glitch on a field write
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_indicator_a <= 1'b0;
			o_indicator_b <= 1'b0;
		end else if (!i_led_ovr[2]) begin
			o_indicator_a <= i_mode_a;
			o_indicator_b <= i_mode_b;
		end else begin
			o_indicator_a <= i_led_ovr[0];
			o_indicator_b <= i_led_ovr[1];
		end
	end

endmodule // phyd_led_drive

// ==== rtl/phyd_regs.sv ====
/*
 * register bank of one PHY port: partner abilities, special control and
 * status, indicator override, cable test engine, status mirror, interrupt.
 * assumes an APB master on i_ref_clk; PHY status levels arrive unsynchronised
 * and the cable test outcome is stable before its done level rises.
 */
// Chosen here: register access over APB.
`timescale 1ns/1ps
module phyd_regs
	import phyd_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_nrst,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// phy core status levels
	input  wire logic [4:0]  i_lp_ability,
	input  wire logic        i_pol_reversed,
	input  wire logic        i_mdix_state,
	// cable test core
	input  wire logic        i_cable_test_done,
	input  wire logic [1:0]  i_cable_test_outcome,
	input  wire logic        i_near_short_flag,
	input  wire logic [8:0]  i_fault_distance_count,
	output logic             o_cable_test_start,
	// phy control levels
	output logic             o_force_link,
	output logic             o_low_power_ten_base_en,
	output logic             o_near_loopback,
	// indicators
	input  wire logic        i_led_mode_a,
	input  wire logic        i_led_mode_b,
	output logic             o_indicator_a,
	output logic             o_indicator_b,
	// interrupt
	output logic             o_irq
);

	// ************************************************************
	// declarations
	// ************************************************************
	logic [19:0]    sync_in;
	logic [19:0]    sync_out;
	logic [4:0]     lp_s;
	logic           pol_s;
	logic           mdix_s;
	logic           done_s;
	logic [1:0]     outcome_s;
	logic           short_s;
	logic [8:0]     count_s;
	logic           done_d_reg;
	logic           pol_d_reg;
	logic           done_evt;
	logic           pol_evt;
	logic           force_link_reg;
	logic           lp10_dis_reg;
	logic           loop_reg;
	logic           cab_rsv_reg;
	logic [2:0]     led_ovr_reg;
	logic           short_reg;
	logic [1:0]     outcome_reg;
	logic [8:0]     count_reg;
	phyd_ct_state_t ct_state_reg;
	logic [11:0]    timer_reg;
	logic           finish_ok;
	logic           finish_to;
	logic           start;
	logic [1:0]     irq_stat_reg;
	logic [1:0]     irq_mask_reg;
	logic [1:0]     irq_set;
	logic [15:0]    ability_word;
	logic [15:0]    special_word;
	logic [15:0]    led_word;
	logic [15:0]    cable_word;
	logic [15:0]    mirror_word;
	logic [31:0]    rd_next;
	logic           hit;
	logic           wr;
	logic           wr_special;
	logic           wr_cable;

	// ************************************************************
	// input synchronisation
	// ************************************************************
	// one group keeps the flop count low; outcome bits settle before done
	assign sync_in = {i_lp_ability, i_pol_reversed, i_mdix_state, i_cable_test_done,
		i_cable_test_outcome, i_near_short_flag, i_fault_distance_count};

	phyd_sync2 #(.WIDTH(20)) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_async   (sync_in),
		.o_sync    (sync_out)
	);

	assign {lp_s, pol_s, mdix_s, done_s, outcome_s, short_s, count_s} = sync_out;

	// edge history for events
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			done_d_reg <= 1'b0;
			pol_d_reg  <= 1'b0;
		end else begin
			done_d_reg <= done_s;
			pol_d_reg  <= pol_s;
		end
	end

	assign done_evt = done_s & ~done_d_reg;
	assign pol_evt  = pol_s ^ pol_d_reg;

	// ************************************************************
	// apb decode
	// ************************************************************
	// zero wait states: every access completes in its first access cycle
	assign o_pready   = 1'b1;
	assign wr         = i_psel & i_penable & i_pwrite;
	assign wr_special = wr & (i_paddr == ADDR_SPECIAL);
	assign wr_cable   = wr & (i_paddr == ADDR_CABLE);
	assign o_pslverr  = i_psel & i_penable & ~hit;

	// ************************************************************
	// control bits
	// ************************************************************
	// force link and loopback are one flop each, seen at two addresses
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			force_link_reg <= 1'b0;
			loop_reg       <= 1'b0;
		end else if (wr_special) begin
			force_link_reg <= i_pwdata[SPC_FORCE_BIT];
			loop_reg       <= i_pwdata[SPC_LOOP_BIT];
		end else if (wr_cable) begin
			force_link_reg <= i_pwdata[CAB_FORCE_BIT];
			loop_reg       <= i_pwdata[CAB_LOOP_BIT];
		end
	end

	// low power select and the spare read/write cable bit
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			lp10_dis_reg <= RST_LP10_DIS;
			cab_rsv_reg  <= RST_CAB_RSV;
		end else begin
			if (wr_special)
				lp10_dis_reg <= i_pwdata[SPC_LP10_BIT];
			if (wr_cable)
				cab_rsv_reg <= i_pwdata[CAB_RSV_BIT];
		end
	end

	// indicator override field
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst)
			led_ovr_reg <= RST_LED_OVR;
		else if (wr & (i_paddr == ADDR_LED_OVR))
			led_ovr_reg <= i_pwdata[LED_OVR_LSB +: 3];
	end

	assign o_force_link            = force_link_reg;
	assign o_low_power_ten_base_en = ~lp10_dis_reg;
	assign o_near_loopback         = loop_reg;

	phyd_led_drive u_led (
		.i_ref_clk     (i_ref_clk),
		.i_nrst        (i_nrst),
		.i_led_ovr     (led_ovr_reg),
		.i_mode_a      (i_led_mode_a),
		.i_mode_b      (i_led_mode_b),
		.o_indicator_a (o_indicator_a),
		.o_indicator_b (o_indicator_b)
	);

	// ************************************************************
	// cable test engine
	// ************************************************************
	// a go write during a running test is ignored, not restarted
	assign start     = wr_cable & i_pwdata[CAB_GO_BIT] & (ct_state_reg == CT_IDLE);
	assign finish_ok = (ct_state_reg == CT_RUN) & done_evt;
	assign finish_to = (ct_state_reg == CT_RUN) & ~done_evt
		& (timer_reg == 12'(CABLE_TIMEOUT_CYC - 1));

	// state, watchdog and start pulse
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ct_state_reg       <= CT_IDLE;
			timer_reg          <= '0;
			o_cable_test_start <= 1'b0;
		end else begin
			o_cable_test_start <= start;
			unique case (ct_state_reg)
				CT_IDLE: begin
					timer_reg <= '0;
					if (start)
						ct_state_reg <= CT_RUN;
				end
				CT_RUN: begin
					timer_reg <= timer_reg + 12'h001;
					if (finish_ok | finish_to)
						ct_state_reg <= CT_IDLE;
				end
			endcase
		end
	end

	// results, held until the next test ends
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			short_reg   <= 1'b0;
			outcome_reg <= 2'h0;
			count_reg   <= 9'h000;
		end else if (finish_ok) begin
			short_reg   <= short_s;
			outcome_reg <= outcome_s;
			count_reg   <= count_s;
		end else if (finish_to) begin
			short_reg   <= 1'b0;
			outcome_reg <= OUT_FAILED;
			count_reg   <= 9'h000;
		end
	end

	// ************************************************************
	// interrupt
	// ************************************************************
	assign irq_set[IRQ_DONE_BIT] = finish_ok | finish_to;
	assign irq_set[IRQ_POL_BIT]  = pol_evt;

	// write one to clear; a new event in the same cycle wins
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_stat_reg <= 2'h0;
			irq_mask_reg <= RST_IRQ_MASK;
		end else begin
			if (wr & (i_paddr == ADDR_IRQ_STAT))
				irq_stat_reg <= (irq_stat_reg & ~i_pwdata[1:0]) | irq_set;
			else
				irq_stat_reg <= irq_stat_reg | irq_set;
			if (wr & (i_paddr == ADDR_IRQ_MASK))
				irq_mask_reg <= i_pwdata[1:0];
		end
	end

	assign o_irq = |(irq_stat_reg & irq_mask_reg);

	// ************************************************************
	// read path
	// ************************************************************
	// unsupported partner features read as zero
	assign ability_word = {3'b000, 2'b00, lp_s[4], 1'b0, lp_s[3:0], ABIL_LOW_RSV};
	assign special_word = {10'h000, pol_s, mdix_s, force_link_reg, lp10_dis_reg,
		loop_reg, 1'b0};
	assign led_word     = {1'b0, led_ovr_reg, 12'h000};
	assign cable_word   = {short_reg, outcome_reg, (ct_state_reg == CT_RUN), force_link_reg,
		cab_rsv_reg, loop_reg, count_reg};
	assign mirror_word  = {2'b00, pol_s, 5'h00, mdix_s, 2'b00, lp_s};

	// address mux; unmapped addresses read zero with an error
	always_comb begin
		rd_next = 32'h0000_0000;
		hit     = 1'b1;
		unique case (i_paddr)
			ADDR_ABILITY:  rd_next[15:0] = ability_word;
			ADDR_SPECIAL:  rd_next[15:0] = special_word;
			ADDR_LED_OVR:  rd_next[15:0] = led_word;
			ADDR_CABLE:    rd_next[15:0] = cable_word;
			ADDR_MIRROR:   rd_next[15:0] = mirror_word;
			ADDR_IRQ_STAT: rd_next[1:0]  = irq_stat_reg;
			ADDR_IRQ_MASK: rd_next[1:0]  = irq_mask_reg;
			default:       hit           = 1'b0;
		endcase
	end

	// captured in the setup cycle so data is a flop output in the access cycle
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst)
			o_prdata <= 32'h0000_0000;
		else if (i_psel & ~i_penable & ~i_pwrite)
			o_prdata <= rd_next;
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_go_write;
		wr_cable && i_pwdata[CAB_GO_BIT] && ct_state_reg == CT_IDLE;
	endsequence

	sequence s_running;
		ct_state_reg == CT_RUN && o_cable_test_start;
	endsequence

	a_pause_mirror: assert property (
		ability_word[10] == lp_s[4] && mirror_word[4] == ability_word[10])
		else $error("pause ability not reported or mirrored");

	a_duplex_bits: assert property (
		ability_word[8:7] == lp_s[3:2] && ability_word[6:5] == lp_s[1:0])
		else $error("partner duplex bits wrong");

	a_unsupported_zero: assert property (
		ability_word[15:13] == 3'b000)
		else $error("unsupported partner bits not zero");

	a_polarity_mirror: assert property (
		$changed(pol_s) |=> irq_stat_reg[IRQ_POL_BIT] && special_word[5] == pol_s
			&& mirror_word[13] == pol_s)
		else $error("polarity not shown in both registers");

	a_force_shared: assert property (
		wr_special |=> o_force_link == $past(i_pwdata[3]) && cable_word[11] == o_force_link)
		else $error("force link not shared between registers");

	a_loop_shared: assert property (
		wr_cable |=> o_near_loopback == $past(i_pwdata[9]) && special_word[1] == o_near_loopback)
		else $error("loopback not shared between registers");

	a_lp10_sense: assert property (
		wr_special |=> o_low_power_ten_base_en == !$past(i_pwdata[SPC_LP10_BIT]))
		else $error("low power select inverted");

	a_led_normal: assert property (
		!led_ovr_reg[2] |=> o_indicator_a == $past(i_led_mode_a)
			&& o_indicator_b == $past(i_led_mode_b))
		else $error("indicators not following normal mode");

	a_led_forced: assert property (
		led_ovr_reg == 3'b101 |=> o_indicator_a && !o_indicator_b)
		else $error("override 101 not lighting only indicator a");

	a_go_start: assert property (
		s_go_write |=> s_running ##1 cable_word[12])
		else $error("cable test did not start");

	a_go_clears: assert property (
		finish_ok |=> !cable_word[12] && cable_word[14:13] == $past(outcome_s)
			&& cable_word[8:0] == $past(count_s))
		else $error("test end did not clear go or capture results");

	a_timeout_fail: assert property (
		finish_to |=> outcome_reg == 2'h3 && ct_state_reg == CT_IDLE)
		else $error("watchdog expiry not reported as failed");

endmodule // phyd_regs

// ==== test/phyd_cable_model.sv ====
/*
 * cable test core model standing behind the port register bank.
 * assumes start is a one-cycle pulse on i_ref_clk; settings come from the bench.
 */
`timescale 1ns/1ps
module phyd_cable_model (
	// clock, reset, start
	input  wire logic       i_ref_clk,
	input  wire logic       i_nrst,
	input  wire logic       i_start,
	// scenario settings
	input  wire logic [1:0] i_cfg_outcome,
	input  wire logic       i_cfg_short,
	input  wire logic [8:0] i_cfg_count,
	input  wire logic       i_cfg_hang,
	// result levels
	output logic            o_done,
	output logic [1:0]      o_outcome,
	output logic            o_short,
	output logic [8:0]      o_count
);
	logic [5:0] cnt_reg;
	logic       busy_reg;

	// results show garbage while measuring, settle long before done rises
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_reg <= 6'h00;
			busy_reg <= 1'b0;
			o_done <= 1'b0;
			{o_outcome, o_short, o_count} <= 12'h000;
		end else if (i_start) begin
			busy_reg <= 1'b1;
			cnt_reg <= 6'h00;
			o_done <= 1'b0;
			{o_outcome, o_short, o_count} <= ~{i_cfg_outcome, i_cfg_short, i_cfg_count};
		end else if (busy_reg) begin
			cnt_reg <= cnt_reg + 6'h01;
			if (cnt_reg == 6'h0A) begin
				{o_outcome, o_short, o_count} <= {i_cfg_outcome, i_cfg_short, i_cfg_count};
			end
			// a hung core never finishes: the bank's watchdog must end it
			if (cnt_reg == 6'h14 && !i_cfg_hang) begin
				busy_reg <= 1'b0;
				o_done <= 1'b1;
			end
		end
	end
endmodule // phyd_cable_model

// ==== test/phyd_port_diag_status_regs_tb_top.sv ====
/*
 * self-checking bench for the port register bank over apb.
 * assumes zero-wait apb slave and the cable core model beside it.
 */
`timescale 1ns/1ps
module phy_port_diag_status_regs_tb_top;
	import phyd_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwd = 32'h0, prd, v;
	logic prdy, perr, err, pol = 1'b0, mdix = 1'b0, done, sh, start, fl, lpen, lb;
	logic ma = 1'b0, mb = 1'b0, ia, ib, irq, c_sh = 1'b0, c_hang = 1'b0;
	logic [4:0] lp = 5'h00;
	logic [1:0] oc, c_oc = 2'h0;
	logic [8:0] fc, c_ct = 9'h000;
	logic [2:0] code;
	int fail_count = 0, tests_run = 0, starts = 0;
	int pos[5] = '{5, 6, 7, 8, 10};

	always #20 clk = ~clk;
	always @(posedge clk) if (start === 1'b1) starts++;

	phyd_regs dut (.i_ref_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
		.o_pslverr(perr), .i_lp_ability(lp), .i_pol_reversed(pol), .i_mdix_state(mdix),
		.i_cable_test_done(done), .i_cable_test_outcome(oc), .i_near_short_flag(sh),
		.i_fault_distance_count(fc), .o_cable_test_start(start), .o_force_link(fl),
		.o_low_power_ten_base_en(lpen), .o_near_loopback(lb), .i_led_mode_a(ma),
		.i_led_mode_b(mb), .o_indicator_a(ia), .o_indicator_b(ib), .o_irq(irq));
	phyd_cable_model cable (.i_ref_clk(clk), .i_nrst(nrst), .i_start(start),
		.i_cfg_outcome(c_oc), .i_cfg_short(c_sh), .i_cfg_count(c_ct), .i_cfg_hang(c_hang),
		.o_done(done), .o_outcome(oc), .o_short(sh), .o_count(fc));

	// ********
	// bus tasks
	// ********
	// one transfer; a spare edge at the end keeps psel from two writes per step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		// no wait-state count assumed: only the watchdog ends a stuck access
		while (prdy !== 1'b1) begin
			@(posedge clk);
		end
		v = prd;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// host sequence: go, poll until clear, then read results
	task automatic cab(input logic [1:0] o, input logic s, input logic [8:0] c, input logic h);
		int n;
		n = 0;
		c_oc <= o;
		c_sh <= s;
		c_ct <= c;
		c_hang <= h;
		apb(1'b1, ADDR_CABLE, 32'h1400);
		apb(1'b0, ADDR_CABLE, 0);
		chk(v & 32'h1000, 32'h1000);
		// a second go while running must not restart the core
		apb(1'b1, ADDR_CABLE, 32'h1400);
		while (v[12] === 1'b1 && n < 2000) begin
			apb(1'b0, ADDR_CABLE, 0);
			n++;
		end
		chk(v, h ? 32'h6400 : {16'h0, s, o, 4'h2, c});
		chk({31'h0, irq}, 1);
		apb(1'b1, ADDR_IRQ_STAT, 32'h1);
		chk({31'h0, irq}, 0);
		$display("cable test outcome %h done", o);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ********
	// tests
	// ********
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk({29'h0, fl, lpen, lb}, 0);
		apb(1'b0, ADDR_SPECIAL, 0);
		chk(v, 32'h4);
		for (int i = 0; i < 5; i++) begin
			lp <= 5'(1 << i);
			repeat (4) @(posedge clk);
			apb(1'b0, ADDR_ABILITY, 0);
			chk(v, 32'h1 | (32'h1 << pos[i]));
			apb(1'b0, ADDR_MIRROR, 0);
			chk(v, 32'h1 << i);
		end
		lp <= 5'h1F;
		pol <= 1'b1;
		mdix <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b1, ADDR_ABILITY, 32'hFFFF);
		apb(1'b0, ADDR_ABILITY, 0);
		chk(v, 32'h05E1);
		apb(1'b0, 12'h004, 0);
		chk({err, v[30:0]}, 32'h80000000);
		apb(1'b0, ADDR_SPECIAL, 0);
		chk({err, v[30:0]}, 32'h34);
		apb(1'b0, ADDR_MIRROR, 0);
		chk(v, 32'h209F);
		$display("status test done");
		// polarity event: masked, unmasked, cleared
		apb(1'b0, ADDR_IRQ_STAT, 0);
		chk({v[31:1], irq}, 32'h2);
		apb(1'b1, ADDR_IRQ_MASK, 32'h3);
		chk({31'h0, irq}, 1);
		apb(1'b1, ADDR_IRQ_STAT, 32'h2);
		chk({31'h0, irq}, 0);
		// shared force and loopback bits, written from both registers
		apb(1'b1, ADDR_SPECIAL, 32'h0A);
		chk({29'h0, fl, lpen, lb}, 7);
		apb(1'b0, ADDR_CABLE, 0);
		chk(v, 32'h0E00);
		apb(1'b1, ADDR_CABLE, 32'h0400);
		chk({29'h0, fl, lpen, lb}, 2);
		apb(1'b0, ADDR_SPECIAL, 0);
		chk(v, 32'h30);
		apb(1'b1, ADDR_SPECIAL, 32'h04);
		chk({31'h0, lpen}, 0);
		$display("control test done");
		for (int i = 0; i < 8; i++) begin
			code = i[2:0];
			ma <= ~code[0];
			mb <= code[1];
			apb(1'b1, ADDR_LED_OVR, {17'h0, code, 12'hFFF});
			@(posedge clk);
			chk({ib, ia}, {code[1], code[2] ? code[0] : ~code[0]});
			apb(1'b0, ADDR_LED_OVR, 0);
			chk(v, {17'h0, code, 12'h000});
		end
		$display("indicator test done");
		cab(2'h0, 1'b0, 9'h000, 1'b0);
		cab(2'h1, 1'b0, 9'h1FF, 1'b0);
		cab(2'h2, 1'b1, 9'h019, 1'b0);
		cab(2'h3, 1'b0, 9'h0AA, 1'b0);
		cab(2'h2, 1'b1, 9'h055, 1'b1);
		chk(starts, 5);
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		tally_and_finish();
	end
endmodule // phy_port_diag_status_regs_tb_top
